/* File: include/motion_cfg_pkg.sv */
// Constants and types for the motion sensor sampling configuration block
// Notes on behaviour
// R01 - Sample rate is gyro output rate divided by one plus 8-bit divider.
// R02 - Gyro output rate is 8kHz for lowpass code 0 or 7, else 1kHz.
// R03 - Registers, buffer, processor and detectors all run at the sample rate.
// R04 - Accel updates at 1kHz; faster sample ticks may repeat one sample.
// R05 - Rate divider is an 8-bit read/write register at 0x19.
// R06 - Any frame sync pin change is latched so short strobes survive.
// R07 - Latch is sampled each sample tick, then reloads the present pin level.
// R08 - 3-bit code picks which low data byte bit 0 carries frame sync.
// R09 - 3-bit lowpass code picks bandwidth; codes 0-6 valid, 7 reserved.
// R10 - Register 0x1A: sync location bits 5:3, lowpass bits 2:0, 7:6 reserved.
// R11 - Register 0x1B bits 7,6,5 start gyro X,Y,Z self-test, any mix.
// R12 - Gyro range bits 4:3 pick 250, 500, 1000 or 2000 deg/s.
// R13 - Register 0x1C bits 7,6,5 start accel X,Y,Z self-test, any mix.
// R14 - Accel range bits 4:3 pick 2, 4, 8 or 16 g.
// R15 - Highpass output feeds only the motion detectors, never data registers.
// R16 - Highpass code 0 is reset: output settles to zero within one sample.
// R17 - Highpass codes 1-4 pass signals above 5, 2.5, 1.25, 0.63 Hz.
// R18 - Highpass code 7 holds the present sample, outputs input minus held.
// R19 - Highpass codes 5 and 6 are reserved and behave as reset.
// R20 - All four configuration registers reset to zero.
package motion_cfg_pkg;
	localparam logic [7:0] ADDR_RATE_DIVIDER = 8'h19;
	localparam logic [7:0] ADDR_SYNC_LOWPASS = 8'h1A;
	localparam logic [7:0] ADDR_GYRO_CFG = 8'h1B;
	localparam logic [7:0] ADDR_ACCEL_CFG = 8'h1C;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] SYNC_LOWPASS_MASK = 8'h3F;
	localparam logic [7:0] GYRO_CFG_MASK = 8'hF8;
	localparam logic [7:0] ACCEL_CFG_MASK = 8'hFF;
	localparam int SYNC_LOC_LSB = 3;
	localparam int LOWPASS_LSB = 0;
	localparam int SELFTEST_LSB = 5;
	localparam int RANGE_LSB = 3;
	localparam int HIGHPASS_LSB = 0;
	localparam logic [2:0] LOWPASS_WIDE = 3'h0;
	localparam logic [2:0] LOWPASS_RESERVED = 3'h7;
	localparam logic [2:0] SYNC_OFF = 3'h0;
	localparam logic [2:0] SYNC_TEMP = 3'h1;
	localparam logic [2:0] SYNC_GYRO_X = 3'h2;
	localparam logic [2:0] SYNC_GYRO_Y = 3'h3;
	localparam logic [2:0] SYNC_GYRO_Z = 3'h4;
	localparam logic [2:0] SYNC_ACCEL_X = 3'h5;
	localparam logic [2:0] SYNC_ACCEL_Y = 3'h6;
	localparam logic [2:0] SYNC_ACCEL_Z = 3'h7;
	localparam logic [2:0] HP_RESET = 3'h0;
	localparam logic [2:0] HP_5HZ = 3'h1;
	localparam logic [2:0] HP_2P5HZ = 3'h2;
	localparam logic [2:0] HP_1P25HZ = 3'h3;
	localparam logic [2:0] HP_0P63HZ = 3'h4;
	localparam logic [2:0] HP_HOLD = 3'h7;
	localparam int HP_SHIFT_5HZ = 5;
	localparam int HP_SHIFT_2P5HZ = 6;
	localparam int HP_SHIFT_1P25HZ = 7;
	localparam int HP_SHIFT_0P63HZ = 8;
	localparam int CLK_RATE_HZ = 10_000_000;
	localparam int GYRO_FAST_HZ = 8000;
	localparam int GYRO_SLOW_HZ = 1000;
	localparam int ACCEL_RATE_HZ = 1000;
	localparam int FAST_PERIOD_CYCLES = CLK_RATE_HZ / GYRO_FAST_HZ;
	localparam int SLOW_PERIOD_CYCLES = CLK_RATE_HZ / GYRO_SLOW_HZ;
	localparam int ACCEL_PERIOD_CYCLES = CLK_RATE_HZ / ACCEL_RATE_HZ;
	localparam int BASE_CNT_W = 16;
	localparam int FRAC_W = 8;

	typedef struct packed {
		logic [15:0] temp;
		logic [2:0][15:0] gyro;
		logic [2:0][15:0] accel;
	} sensor_frame_type;

	typedef logic [2:0][15:0] axis_vector_type;

	typedef struct packed {
		logic [7:0] rate_divider;
		logic [7:0] sync_and_lowpass_config;
		logic [7:0] gyro_range_selftest;
		logic [7:0] accel_range_selftest_highpass;
	} cfg_regs_type;

	typedef struct packed {
		cfg_regs_type regs;
		logic [7:0] rdata;
		logic [BASE_CNT_W-1:0] base_cnt;
		logic [BASE_CNT_W-1:0] accel_cnt;
		logic [7:0] div_cnt;
		logic sync_ref;
		logic sync_latch;
		logic sample_tick;
		axis_vector_type accel_held;
		sensor_frame_type data;
		logic [2:0][23:0] hp_track;
		axis_vector_type hp_ref;
		logic hp_armed;
		axis_vector_type hp_out;
		logic hp_valid;
		logic gyro_fast;
	} core_state_type;
endpackage

/* File: verilog/motion_sensor_sampling_config.sv */
// Sample rate, frame sync capture, range, self-test and highpass control
`timescale 1ns/1ps
module motion_sensor_sampling_config
	import motion_cfg_pkg::*;
#(
	parameter int SLOW_PERIOD = SLOW_PERIOD_CYCLES, // 1kHz base period
	parameter int FAST_PERIOD = FAST_PERIOD_CYCLES, // 8kHz base period
	parameter int ACCEL_PERIOD = ACCEL_PERIOD_CYCLES // 1kHz accel period
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	input wire logic frame_sync_in, // Frame sync pin
	input wire sensor_frame_type sensor_raw, // Raw converter samples
	output logic sample_tick, // One pulse per sample period
	output sensor_frame_type data_out, // Sensor data registers
	output axis_vector_type hp_out, // Highpass result to detectors
	output logic hp_valid, // Pulse with each highpass result
	output logic [2:0] gyro_selftest, // X,Y,Z gyro self-test drive
	output logic [1:0] gyro_range, // Gyro full scale code
	output logic [2:0] accel_selftest, // X,Y,Z accel self-test drive
	output logic [1:0] accel_range, // Accel full scale code
	output logic [2:0] lowpass_code, // Lowpass bandwidth code
	output logic gyro_fast_rate // Gyro path at 8kHz
);

	core_state_type q;
	core_state_type d;

	// Clamp a 17-bit difference into a 16-bit sample
	function automatic logic [15:0] clamp16(input logic signed [16:0] v);
		logic [15:0] r;
		r = v[15:0];
		if (v > 17'sd32767) begin
			r = 16'h7FFF;
		end else if (v < -17'sd32768) begin
			r = 16'h8000;
		end
		return r;
	endfunction

	// Tracking shift per cut-off; wider shift means lower corner
	function automatic int hp_shift(input logic [2:0] code);
		int s;
		s = HP_SHIFT_5HZ;
		case (code)
			HP_2P5HZ: begin
				s = HP_SHIFT_2P5HZ;
			end
			HP_1P25HZ: begin
				s = HP_SHIFT_1P25HZ;
			end
			HP_0P63HZ: begin
				s = HP_SHIFT_0P63HZ;
			end
			default: begin
				s = HP_SHIFT_5HZ;
			end
		endcase
		return s;
	endfunction

	logic [2:0] sync_loc;
	logic [2:0] lp_code;
	logic [2:0] hp_code;
	logic fast;
	logic base_tick;
	logic accel_tick;
	logic sample_now;
	logic sync_bit;
	axis_vector_type accel_src;
	logic signed [23:0] xe;
	logic signed [24:0] diff;
	logic signed [24:0] step;
	logic signed [16:0] delta;
	logic [BASE_CNT_W-1:0] period_last;

	// Next-state logic for the whole block
	always_comb begin
		d = q;
		d.sample_tick = 1'b0;
		d.hp_valid = 1'b0;
		d.rdata = 8'h00;
		xe = '0;
		diff = '0;
		step = '0;
		delta = '0;
		sync_loc = q.regs.sync_and_lowpass_config[SYNC_LOC_LSB +: 3];
		lp_code = q.regs.sync_and_lowpass_config[LOWPASS_LSB +: 3];
		hp_code = q.regs.accel_range_selftest_highpass[HIGHPASS_LSB +: 3];

		// Register writes; reserved bits are masked so they read zero
		if (reg_wr) begin
			case (reg_addr)
				ADDR_RATE_DIVIDER: begin
					d.regs.rate_divider = reg_wdata; // [R05]
				end
				ADDR_SYNC_LOWPASS: begin
					d.regs.sync_and_lowpass_config =
						reg_wdata & SYNC_LOWPASS_MASK; // [R10]
				end
				ADDR_GYRO_CFG: begin
					d.regs.gyro_range_selftest =
						reg_wdata & GYRO_CFG_MASK; // [R11] [R12]
				end
				ADDR_ACCEL_CFG: begin
					d.regs.accel_range_selftest_highpass =
						reg_wdata & ACCEL_CFG_MASK; // [R13] [R14]
				end
				default: begin
				end
			endcase
		end

		// Rate decode follows the register image so the port is a flop
		d.gyro_fast = (d.regs.sync_and_lowpass_config[LOWPASS_LSB +: 3] ==
			LOWPASS_WIDE) ||
			(d.regs.sync_and_lowpass_config[LOWPASS_LSB +: 3] ==
			LOWPASS_RESERVED); // [R02]

		// Register reads; unmapped addresses answer zero
		if (reg_rd) begin
			case (reg_addr)
				ADDR_RATE_DIVIDER: begin
					d.rdata = q.regs.rate_divider; // [R05]
				end
				ADDR_SYNC_LOWPASS: begin
					d.rdata = q.regs.sync_and_lowpass_config; // [R10]
				end
				ADDR_GYRO_CFG: begin
					d.rdata = q.regs.gyro_range_selftest;
				end
				ADDR_ACCEL_CFG: begin
					d.rdata = q.regs.accel_range_selftest_highpass;
				end
				default: begin
					d.rdata = 8'h00;
				end
			endcase
		end

		// Gyro output rate: filter bypass codes run the fast path
		fast = (lp_code == LOWPASS_WIDE) ||
			(lp_code == LOWPASS_RESERVED); // [R02] [R09]
		period_last = fast ? BASE_CNT_W'(FAST_PERIOD - 1) :
			BASE_CNT_W'(SLOW_PERIOD - 1); // [R02]
		// Compare with >= so a rate change never strands the counter
		base_tick = (q.base_cnt >= period_last);
		d.base_cnt = base_tick ? '0 : q.base_cnt + 1'b1;

		// Accel converter delivers a fresh sample at its own fixed rate
		accel_tick = (q.accel_cnt >= BASE_CNT_W'(ACCEL_PERIOD - 1));
		d.accel_cnt = accel_tick ? '0 : q.accel_cnt + 1'b1;
		accel_src = accel_tick ? sensor_raw.accel : q.accel_held;
		if (accel_tick) begin
			d.accel_held = sensor_raw.accel; // [R04]
		end

		// Divider: one sample tick per (1 + divider) base ticks
		sample_now = base_tick &&
			(q.div_cnt >= q.regs.rate_divider); // [R01]
		if (base_tick) begin
			d.div_cnt = sample_now ? 8'h00 : q.div_cnt + 8'h01; // [R01]
		end

		// Frame sync latch: first deviation from the reload level sticks
		if (frame_sync_in != q.sync_ref) begin
			d.sync_latch = ~q.sync_ref; // [R06]
		end
		// A change in the sampling cycle itself still counts
		sync_bit = (frame_sync_in != q.sync_ref) ? ~q.sync_ref :
			q.sync_latch; // [R06]

		if (sample_now) begin
			d.sample_tick = 1'b1; // [R03]
			d.sync_ref = frame_sync_in; // [R07]
			d.sync_latch = frame_sync_in; // [R07]
			// Data registers take unfiltered samples only
			d.data.temp = sensor_raw.temp; // [R03] [R15]
			d.data.gyro = sensor_raw.gyro;
			// Same accel word may repeat at fast sample rates
			d.data.accel = accel_src; // [R04]

			// Frame sync replaces bit 0 of the selected low byte
			unique case (sync_loc)
				SYNC_OFF: begin
				end
				SYNC_TEMP: begin
					d.data.temp[0] = sync_bit; // [R08]
				end
				SYNC_GYRO_X: begin
					d.data.gyro[0][0] = sync_bit; // [R08]
				end
				SYNC_GYRO_Y: begin
					d.data.gyro[1][0] = sync_bit; // [R08]
				end
				SYNC_GYRO_Z: begin
					d.data.gyro[2][0] = sync_bit; // [R08]
				end
				SYNC_ACCEL_X: begin
					d.data.accel[0][0] = sync_bit; // [R08]
				end
				SYNC_ACCEL_Y: begin
					d.data.accel[1][0] = sync_bit; // [R08]
				end
				SYNC_ACCEL_Z: begin
					d.data.accel[2][0] = sync_bit; // [R08]
				end
			endcase

			// Highpass on the detector path, one update per sample
			d.hp_valid = 1'b1; // [R03] [R15]
			for (int i = 0; i < 3; i++) begin
				xe = {accel_src[i], 8'h00};
				diff = 25'(xe) - 25'($signed(q.hp_track[i]));
				case (hp_code)
					HP_5HZ, HP_2P5HZ, HP_1P25HZ, HP_0P63HZ: begin
						// Track the low band, output what is left
						step = diff >>> hp_shift(hp_code); // [R17]
						d.hp_track[i] = 24'($signed(q.hp_track[i]) +
							step); // [R17]
						delta = 17'(diff >>> FRAC_W);
						d.hp_out[i] = clamp16(delta); // [R17]
					end
					HP_HOLD: begin
						if (!q.hp_armed) begin
							// First sample after the trigger is stored
							d.hp_ref[i] = accel_src[i]; // [R18]
							d.hp_out[i] = 16'h0000;
						end else begin
							delta = 17'($signed(accel_src[i])) -
								17'($signed(q.hp_ref[i]));
							d.hp_out[i] = clamp16(delta); // [R18]
						end
					end
					default: begin
						// Reset and reserved codes: snap tracker to input
						d.hp_track[i] = xe; // [R16] [R19]
						d.hp_out[i] = 16'h0000; // [R16] [R19]
					end
				endcase
			end
			if (hp_code == HP_HOLD) begin
				d.hp_armed = 1'b1; // [R18]
			end
		end

		// Leaving hold mode re-arms the trigger for the next entry
		if (hp_code != HP_HOLD) begin
			d.hp_armed = 1'b0; // [R18]
		end
	end

	// State register; all fields but gyro_fast clear on reset, gyro_fast sets
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0; // [R20]
			q.gyro_fast <= 1'b1; // Code 0 after reset is the fast path
		end else begin
			q <= d;
		end
	end

	// Outputs come straight from state flops
	assign reg_rdata = q.rdata;
	assign sample_tick = q.sample_tick;
	assign data_out = q.data;
	assign hp_out = q.hp_out;
	assign hp_valid = q.hp_valid;
	// Self-test buses keep X in the top bit, as in the register
	assign gyro_selftest = {q.regs.gyro_range_selftest[SELFTEST_LSB+2],
		q.regs.gyro_range_selftest[SELFTEST_LSB+1],
		q.regs.gyro_range_selftest[SELFTEST_LSB]}; // [R11]
	assign gyro_range = q.regs.gyro_range_selftest[RANGE_LSB +: 2]; // [R12]
	assign accel_selftest =
		{q.regs.accel_range_selftest_highpass[SELFTEST_LSB+2],
		q.regs.accel_range_selftest_highpass[SELFTEST_LSB+1],
		q.regs.accel_range_selftest_highpass[SELFTEST_LSB]}; // [R13]
	assign accel_range =
		q.regs.accel_range_selftest_highpass[RANGE_LSB +: 2]; // [R14]
	assign lowpass_code =
		q.regs.sync_and_lowpass_config[LOWPASS_LSB +: 3]; // [R09]
	// Rate flag registered beside the code it decodes
	assign gyro_fast_rate = q.gyro_fast; // [R02]

endmodule

/* File: verif/motion_sensor_sampling_config_assertions.sv */
// Bound checker for the sampling configuration block
`timescale 1ns/1ps
module motion_sensor_sampling_config_assertions
	import motion_cfg_pkg::*;
#(
	parameter int SLOW_PERIOD = SLOW_PERIOD_CYCLES, // Slow base period
	parameter int FAST_PERIOD = FAST_PERIOD_CYCLES, // Fast base period
	parameter int ACCEL_PERIOD = ACCEL_PERIOD_CYCLES // Accel period
) (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic [7:0] reg_addr, // Address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic sample_tick, // Sample pulse
	input wire sensor_frame_type data_out, // Data registers
	input wire logic hp_valid, // Highpass pulse
	input wire logic [2:0] gyro_selftest, // Gyro self-test
	input wire logic [1:0] gyro_range, // Gyro range
	input wire logic [2:0] accel_selftest, // Accel self-test
	input wire logic [1:0] accel_range, // Accel range
	input wire logic [2:0] lowpass_code, // Lowpass code
	input wire logic gyro_fast_rate // Fast gyro path
);
	// One clock domain, so one default for all
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_sync_reserved: assert property (
		reg_rd && reg_addr == 8'h1A |=> reg_rdata[7:6] == 2'b00)
		else $error("reserved sync bits read nonzero");
	a_gyro_reserved: assert property (
		reg_rd && reg_addr == 8'h1B |=> reg_rdata[2:0] == 3'h0)
		else $error("reserved gyro bits read nonzero");
	a_lowpass_write: assert property (
		reg_wr && reg_addr == 8'h1A |=> lowpass_code == $past(reg_wdata[2:0]))
		else $error("lowpass code not written");
	a_gyro_write: assert property (reg_wr && reg_addr == 8'h1B |=>
		{gyro_selftest, gyro_range} == $past(reg_wdata[7:3]))
		else $error("gyro fields not written");
	a_accel_write: assert property (reg_wr && reg_addr == 8'h1C |=>
		{accel_selftest, accel_range} == $past(reg_wdata[7:3]))
		else $error("accel fields not written");
	a_fast_map: assert property (
		gyro_fast_rate == (lowpass_code == 3'h0 || lowpass_code == 3'h7))
		else $error("fast rate decode wrong");
	a_tick_pulse: assert property (sample_tick |=> !sample_tick)
		else $error("sample pulse longer than one cycle");
	a_hp_paced: assert property (hp_valid == sample_tick)
		else $error("highpass result off the sample pulse");
	a_data_hold: assert property (!sample_tick |-> $stable(data_out))
		else $error("data changed between samples");
endmodule

bind motion_sensor_sampling_config motion_sensor_sampling_config_assertions #(
	.SLOW_PERIOD(SLOW_PERIOD), .FAST_PERIOD(FAST_PERIOD),
	.ACCEL_PERIOD(ACCEL_PERIOD)
) i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .sample_tick(sample_tick), .data_out(data_out),
	.hp_valid(hp_valid), .gyro_selftest(gyro_selftest),
	.gyro_range(gyro_range), .accel_selftest(accel_selftest),
	.accel_range(accel_range), .lowpass_code(lowpass_code),
	.gyro_fast_rate(gyro_fast_rate));

/* File: verif/motion_sensor_sampling_config_tb.sv */
// Self-checking bench for the sampling configuration block
`timescale 1ns/1ps
module motion_sensor_sampling_config_tb import motion_cfg_pkg::*;;
	localparam sensor_frame_type RAW = {16'h1110, 16'h2220, 16'h3330,
		16'h4440, 16'h5550, 16'h6660, 16'h7770};
	// Readback per address 0x19..0x1D, last one unmapped
	localparam logic [4:0][7:0] MASKS = {8'h00, 8'hFF, 8'hF8, 8'h3F, 8'hFF};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic frame_sync_in = 1'b0;
	sensor_frame_type sensor_raw = RAW;
	logic [7:0] reg_rdata;
	logic sample_tick, hp_valid, gyro_fast_rate;
	sensor_frame_type data_out;
	axis_vector_type hp_out;
	logic [2:0] gyro_selftest, accel_selftest, lowpass_code;
	logic [1:0] gyro_range, accel_range;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	// Short periods keep the run small
	motion_sensor_sampling_config #(.SLOW_PERIOD(40), .FAST_PERIOD(8),
		.ACCEL_PERIOD(40)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_sync_in(frame_sync_in), .sensor_raw(sensor_raw),
		.sample_tick(sample_tick), .data_out(data_out), .hp_out(hp_out),
		.hp_valid(hp_valid), .gyro_selftest(gyro_selftest),
		.gyro_range(gyro_range), .accel_selftest(accel_selftest),
		.accel_range(accel_range), .lowpass_code(lowpass_code),
		.gyro_fast_rate(gyro_fast_rate));

	always #50 clk_sys = ~clk_sys;

	task automatic report_and_stop;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask

	// Bounded by the hang guard
	task automatic wait_tick;
		do @(negedge clk_sys); while (sample_tick !== 1'b1);
	endtask

	task automatic t_reset;
		logic [7:0] d;
		for (int a = 8'h19; a < 8'h1D; a++) begin
			rd(8'(a), d);
			chk(d, 8'h00);
		end
	endtask

	task automatic t_regs;
		logic [7:0] d;
		for (int a = 8'h19; a < 8'h1E; a++) begin
			wr(8'(a), 8'hFF);
			rd(8'(a), d);
			chk(d, MASKS[a - 8'h19]);
		end
		chk({gyro_selftest, gyro_range, accel_selftest, accel_range,
			lowpass_code, gyro_fast_rate}, 14'h3FFF);
		// Uneven self-test patterns expose a swapped axis order
		wr(8'h1B, 8'hC8);
		wr(8'h1C, 8'h30);
		wr(8'h1A, 8'h02);
		@(negedge clk_sys);
		chk({gyro_selftest, gyro_range, accel_selftest, accel_range,
			lowpass_code, gyro_fast_rate}, {3'h6, 2'h1, 3'h1, 2'h2, 3'h2,
			1'b0});
	endtask

	// Second full interval is free of the switch-over
	task automatic t_rate(input logic [7:0] lp, input int exp);
		int n;
		wr(8'h1A, lp);
		wait_tick();
		wait_tick();
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (sample_tick !== 1'b1);
		chk(n, exp);
	endtask

	// One-cycle strobe between samples, then a quiet sample
	task automatic t_sync;
		sensor_frame_type e;
		wr(8'h19, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(8'h1A, 8'(c << 3));
			wait_tick();
			wait_tick();
			@(posedge clk_sys);
			frame_sync_in <= 1'b1;
			@(posedge clk_sys);
			frame_sync_in <= 1'b0;
			e = RAW;
			if (c == 1) e.temp[0] = 1'b1;
			else if (c > 1 && c < 5) e.gyro[c - 2][0] = 1'b1;
			else if (c > 4) e.accel[c - 5][0] = 1'b1;
			wait_tick();
			chk(data_out, e);
			wait_tick();
			chk(data_out, RAW);
		end
	endtask

	// Nonzero results come first so zeroing by codes 0 and 6 can be seen
	task automatic t_hp;
		sensor_frame_type s;
		s = RAW;
		s.accel = {16'h5560, 16'h6670, 16'h7780};
		wr(8'h1A, 8'h01);
		wr(8'h1C, 8'h07);
		wait_tick();
		wait_tick();
		chk(hp_out, 48'h0);
		@(posedge clk_sys);
		sensor_raw <= s;
		repeat (3) wait_tick();
		chk(hp_out, {3{16'h0010}});
		chk(data_out, s);
		wr(8'h1C, 8'h00);
		wait_tick();
		wait_tick();
		chk(hp_out, 48'h0);
		// Re-entering hold stores a fresh reference
		wr(8'h1C, 8'h07);
		wait_tick();
		wait_tick();
		@(posedge clk_sys);
		sensor_raw <= RAW;
		repeat (3) wait_tick();
		chk(hp_out, {3{16'hFFF0}});
		wr(8'h1C, 8'h06);
		wait_tick();
		wait_tick();
		chk(hp_out, 48'h0);
		// Tracker sits on RAW; a step passes whole, then starts to decay
		wr(8'h1C, 8'h01);
		@(posedge clk_sys);
		sensor_raw <= s;
		do wait_tick(); while (hp_out === 48'h0);
		chk(hp_out, {3{16'h0010}});
		wait_tick();
		chk(hp_out, {3{16'h000F}});
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		wr(8'h19, 8'h02);
		t_rate(8'h00, 24);
		t_rate(8'h07, 24);
		t_rate(8'h03, 120);
		t_sync();
		t_hp();
		report_and_stop();
	end
endmodule
